// >>> rtl/swv_top.sv
`timescale 1ns/1ns
`default_nettype none
module swv_top #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0000_1234_5678 // Arbitrary
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic busReset,
  input wire logic stdSpeedReset,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxPartial,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  input wire logic [159:0] authCode,
  output logic overdriveMode,
  output logic copyStrobe,
  output logic secretLoadStrobe,
  output logic [15:0] targetAddr,
  output logic [63:0] scratchData,
  output logic [7:0] transferStatus
);
  swv_pkg::swv_state_e state_q, state_d;
  logic od_q, od_d;
  logic rc_q, rc_d;
  logic [7:0] ta1_q, ta1_d;
  logic [7:0] ta2_q, ta2_d;
  logic pf_q, pf_d;
  logic aa_q, aa_d;
  logic [7:0] pad_q [swv_pkg::PAD_BYTES];
  logic [7:0] pad_d [swv_pkg::PAD_BYTES];
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] txIdx_q, txIdx_d;
  logic romTx_q, romTx_d;
  logic [7:0] txByte_q, txByte_d;
  logic [15:0] crc_q, crc_d;
  logic [159:0] mac_q, mac_d;
  logic copy_q, copy_d;
  logic sec_q, sec_d;
  logic [63:0] regNum;
  logic [63:0] padFlat;
  logic [7:0] romCrc;
  logic [7:0] romCheck;
  logic [15:0] crcSeed;
  logic [15:0] crcNext;
  logic [7:0] crcByte;
  logic [7:0] esValue;
  logic rxWhole;
  logic txFire;

  function automatic logic [7:0] romByte(logic [63:0] r, logic [2:0] i);
    return r[{i, 3'b000} +: 8];
  endfunction

  function automatic logic [7:0] padByte(logic [63:0] p, logic [3:0] i,
                                         logic [7:0] t1, logic [7:0] t2,
                                         logic [7:0] es, logic [15:0] c);
    logic [3:0] k;
    k = i - swv_pkg::TX_PAD0;
    case (i)
      swv_pkg::TX_TA1: return t1;
      swv_pkg::TX_TA2: return t2;
      swv_pkg::TX_ES: return es;
      swv_pkg::TX_CRC_LO: return ~c[7:0];
      swv_pkg::TX_CRC_HI: return ~c[15:8];
      default: return p[{k[2:0], 3'b000} +: 8];
    endcase
  endfunction

  swv_crc8 #(.NBITS(56)) uRomCrc (
    .dataIn({8'h00, SERIAL_NUMBER, FAMILY_CODE}),
    .crcOut(romCrc)
  );

  swv_crc8 #(.NBITS(64)) uRomCheck (
    .dataIn(regNum),
    .crcOut(romCheck)
  );

  swv_crc16 uCrc16 (
    .crcIn(crcSeed),
    .dataIn(crcByte),
    .crcOut(crcNext)
  );

  assign regNum = {romCrc, SERIAL_NUMBER, FAMILY_CODE};
  // Fixed ones plus the two live flags; no write path exists
  assign esValue = swv_pkg::ES_FIXED_ONES
                 | ({7'b0, aa_q} << swv_pkg::AA_BIT)
                 | ({7'b0, pf_q} << swv_pkg::PF_BIT);
  assign rxWhole = rxValid && !rxPartial;
  assign txValid = (state_q == swv_pkg::ST_TX);
  assign txFire = txValid && txReady;
  assign crcSeed = (state_q == swv_pkg::ST_FUNC) ? 16'h0000 : crc_q;
  assign crcByte = (state_q == swv_pkg::ST_TX) ? txByte_q : rxData;

  always_comb begin
    for (int i = 0; i < swv_pkg::PAD_BYTES; i++) begin
      padFlat[i*8 +: 8] = pad_q[i];
    end
  end

  always_comb begin
    state_d = state_q;
    od_d = od_q;
    rc_d = rc_q;
    ta1_d = ta1_q;
    ta2_d = ta2_q;
    pf_d = pf_q;
    aa_d = aa_q;
    pad_d = pad_q;
    cnt_d = cnt_q;
    txIdx_d = txIdx_q;
    romTx_d = romTx_q;
    txByte_d = txByte_q;
    crc_d = crc_q;
    mac_d = mac_q;
    copy_d = 1'b0;
    sec_d = 1'b0;
    if (busReset) begin
      state_d = swv_pkg::ST_ROM;
    end else begin
      case (state_q)
        swv_pkg::ST_IDLE: begin
          state_d = swv_pkg::ST_IDLE;
        end
        swv_pkg::ST_ROM: begin
          if (rxValid && rxPartial) begin
            state_d = swv_pkg::ST_HOLD;
          end else if (rxWhole) begin
            case (rxData)
              swv_pkg::CMD_READ_ROM: begin
                state_d = swv_pkg::ST_TX;
                romTx_d = 1'b1;
                txIdx_d = 4'h0;
                txByte_d = romByte(regNum, 3'd0);
              end
              swv_pkg::CMD_SKIP_ROM: begin
                state_d = swv_pkg::ST_FUNC;
              end
              swv_pkg::CMD_OD_SKIP: begin
                od_d = 1'b1;
                state_d = swv_pkg::ST_FUNC;
              end
              swv_pkg::CMD_MATCH_ROM, swv_pkg::CMD_OD_MATCH: begin
                if (rxData == swv_pkg::CMD_OD_MATCH) begin
                  od_d = 1'b1;
                end
                rc_d = 1'b0;
                cnt_d = 5'd0;
                state_d = swv_pkg::ST_MATCH;
              end
              swv_pkg::CMD_RESUME: begin
                state_d = rc_q ? swv_pkg::ST_FUNC : swv_pkg::ST_HOLD;
              end
              default: begin
                state_d = swv_pkg::ST_HOLD;
              end
            endcase
          end
        end
        swv_pkg::ST_MATCH: begin
          if (rxWhole && rxData == romByte(regNum, cnt_q[2:0])) begin
            if (cnt_q == 5'(swv_pkg::ROM_BYTES - 1)) begin
              rc_d = 1'b1;
              state_d = swv_pkg::ST_FUNC;
            end else begin
              cnt_d = cnt_q + 5'd1;
            end
          end else if (rxValid) begin
            state_d = swv_pkg::ST_HOLD;
          end
        end
        swv_pkg::ST_FUNC: begin
          if (rxValid && rxPartial) begin
            state_d = swv_pkg::ST_HOLD;
          end else if (rxWhole) begin
            crc_d = crcNext;
            cnt_d = 5'd0;
            case (rxData)
              swv_pkg::CMD_WRITE_PAD, swv_pkg::CMD_REFRESH_PAD: begin
                aa_d = 1'b0;
                pf_d = 1'b1;
                state_d = swv_pkg::ST_ADDR;
              end
              swv_pkg::CMD_READ_PAD: begin
                romTx_d = 1'b0;
                txIdx_d = swv_pkg::TX_TA1;
                txByte_d = ta1_q;
                state_d = swv_pkg::ST_TX;
              end
              swv_pkg::CMD_COPY_PAD: begin
                state_d = swv_pkg::ST_MAC;
              end
              swv_pkg::CMD_LOAD_SECRET: begin
                if (!pf_q) begin
                  sec_d = 1'b1;
                  aa_d = 1'b1;
                end
                state_d = swv_pkg::ST_HOLD;
              end
              default: begin
                state_d = swv_pkg::ST_HOLD;
              end
            endcase
          end
        end
        swv_pkg::ST_ADDR: begin
          if (rxValid && rxPartial) begin
            state_d = swv_pkg::ST_HOLD;
          end else if (rxWhole) begin
            crc_d = crcNext;
            if (cnt_q == 5'd0) begin
              ta1_d = rxData & swv_pkg::TA1_KEEP_MASK;
              cnt_d = 5'd1;
            end else begin
              ta2_d = rxData;
              cnt_d = 5'd0;
              state_d = swv_pkg::ST_DATA;
            end
          end
        end
        swv_pkg::ST_DATA: begin
          if (rxValid && rxPartial) begin
            pf_d = 1'b1;
            state_d = swv_pkg::ST_HOLD;
          end else if (rxWhole) begin
            pad_d[cnt_q[2:0]] = rxData;
            crc_d = crcNext;
            if (cnt_q == 5'(swv_pkg::PAD_BYTES - 1)) begin
              pf_d = 1'b0;
              romTx_d = 1'b0;
              txIdx_d = swv_pkg::TX_CRC_LO;
              txByte_d = ~crcNext[7:0];
              state_d = swv_pkg::ST_TX;
            end else begin
              cnt_d = cnt_q + 5'd1;
            end
          end
        end
        swv_pkg::ST_MAC: begin
          if (rxValid && rxPartial) begin
            state_d = swv_pkg::ST_HOLD;
          end else if (rxWhole) begin
            mac_d = {rxData, mac_q[159:8]};
            if (cnt_q == 5'(swv_pkg::MAC_BYTES - 1)) begin
              if (mac_d == authCode && !pf_q) begin
                copy_d = 1'b1;
                aa_d = 1'b1;
              end
              state_d = swv_pkg::ST_HOLD;
            end else begin
              cnt_d = cnt_q + 5'd1;
            end
          end
        end
        swv_pkg::ST_TX: begin
          if (txFire && romTx_q) begin
            if (txIdx_q == 4'(swv_pkg::ROM_BYTES - 1)) begin
              state_d = swv_pkg::ST_HOLD;
            end else begin
              txIdx_d = txIdx_q + 4'd1;
              txByte_d = romByte(regNum, txIdx_d[2:0]);
            end
          end else if (txFire) begin
            if (txIdx_q < swv_pkg::TX_CRC_LO) begin
              crc_d = crcNext;
            end
            if (txIdx_q == swv_pkg::TX_CRC_HI) begin
              state_d = swv_pkg::ST_HOLD;
            end else begin
              txIdx_d = txIdx_q + 4'd1;
              txByte_d = padByte(padFlat, txIdx_d, ta1_q, ta2_q, esValue,
                                 crc_d);
            end
          end
        end
        swv_pkg::ST_HOLD: begin
          state_d = swv_pkg::ST_HOLD;
        end
        default: begin
          state_d = swv_pkg::ST_IDLE;
        end
      endcase
    end
    if (stdSpeedReset) begin
      od_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= swv_pkg::ST_IDLE;
      od_q <= 1'b0;
      rc_q <= 1'b0;
      ta1_q <= 8'h00;
      ta2_q <= 8'h00;
      pf_q <= swv_pkg::PF_RESET;
      aa_q <= swv_pkg::AA_RESET;
      for (int i = 0; i < swv_pkg::PAD_BYTES; i++) begin
        pad_q[i] <= 8'h00;
      end
      cnt_q <= 5'd0;
      txIdx_q <= 4'h0;
      romTx_q <= 1'b0;
      txByte_q <= 8'h00;
      crc_q <= 16'h0000;
      mac_q <= '0;
      copy_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      state_q <= state_d;
      od_q <= od_d;
      rc_q <= rc_d;
      ta1_q <= ta1_d;
      ta2_q <= ta2_d;
      pf_q <= pf_d;
      aa_q <= aa_d;
      pad_q <= pad_d;
      cnt_q <= cnt_d;
      txIdx_q <= txIdx_d;
      romTx_q <= romTx_d;
      txByte_q <= txByte_d;
      crc_q <= crc_d;
      mac_q <= mac_d;
      copy_q <= copy_d;
      sec_q <= sec_d;
    end
  end

  assign txData = txByte_q;
  assign overdriveMode = od_q;
  assign copyStrobe = copy_q;
  assign secretLoadStrobe = sec_q;
  assign targetAddr = {ta2_q, ta1_q};
  assign scratchData = padFlat;
  assign transferStatus = esValue;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ROM_CRC: assert property (romCheck == 8'h00)
    else $error("Registration CRC does not check to zero");
  AST_TA1_LOW: assert property (ta1_q[2:0] == 3'b000)
    else $error("Low target address bits not zero");
  AST_ES_ENDING: assert property (transferStatus[2:0] == 3'b111)
    else $error("Ending offset not all ones");
  AST_ES_UNUSED: assert property (
    transferStatus[6] && transferStatus[4] && transferStatus[3])
    else $error("Unused status bits not one");
  AST_PF_PARTIAL: assert property (
    !busReset && state_q == swv_pkg::ST_DATA && rxValid && rxPartial
    |=> pf_q && transferStatus[5] && state_q == swv_pkg::ST_HOLD)
    else $error("Partial byte did not set flag");
  AST_PF_CLEAR: assert property (
    !busReset && state_q == swv_pkg::ST_DATA && rxWhole && cnt_q == 5'd7
    |=> !pf_q && txValid && txIdx_q == swv_pkg::TX_CRC_LO)
    else $error("Full write did not clear flag");
  AST_AA_CLEAR: assert property (
    !busReset && state_q == swv_pkg::ST_FUNC && rxWhole
    && (rxData == swv_pkg::CMD_WRITE_PAD
        || rxData == swv_pkg::CMD_REFRESH_PAD)
    |=> !aa_q && pf_q)
    else $error("Write did not clear authorization flag");
  AST_ES_RO: assert property (
    state_q == swv_pkg::ST_TX && !busReset |=> $stable(transferStatus))
    else $error("Status changed during a read");
  AST_WR_CRC: assert property (
    $rose(txValid) && txIdx_q == swv_pkg::TX_CRC_LO
    |-> txData == ~crc_q[7:0] ##1 1'b1)
    else $error("Write CRC byte wrong");
  AST_COPY_MAC: assert property (
    copyStrobe |-> mac_q == authCode && aa_q && !pf_q)
    else $error("Copy without matching code");
  AST_SECRET: assert property (
    secretLoadStrobe |-> aa_q && $past(state_q) == swv_pkg::ST_FUNC)
    else $error("Secret load out of sequence");
  AST_FUNC_GATE: assert property (
    state_q == swv_pkg::ST_FUNC && $past(state_q) != swv_pkg::ST_FUNC
    |-> $past(state_q) == swv_pkg::ST_ROM
        || $past(state_q) == swv_pkg::ST_MATCH)
    else $error("Function level reached without ROM command");
  AST_OD: assert property (
    state_q == swv_pkg::ST_ROM && rxWhole && !busReset && !stdSpeedReset
    && rxData == swv_pkg::CMD_OD_SKIP |=> od_q && overdriveMode)
    else $error("Overdrive not entered");
  AST_BUS_RESET: assert property (
    busReset |=> state_q == swv_pkg::ST_ROM && !txValid)
    else $error("Bus reset did not restart transaction");

  COV_WRITE: cover property (state_q == swv_pkg::ST_DATA && rxWhole
                             && cnt_q == 5'd7);
  COV_READ: cover property (txFire && txIdx_q == swv_pkg::TX_CRC_HI);
  COV_COPY: cover property (copyStrobe);
  COV_MATCH: cover property (state_q == swv_pkg::ST_MATCH && rc_d);
endmodule
`default_nettype wire

// >>> pkg/swv_pkg.sv
`default_nettype none
package swv_pkg;
  // ROM-level command bytes
  localparam logic [7:0] CMD_READ_ROM = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM = 8'hcc;
  localparam logic [7:0] CMD_RESUME = 8'ha5;
  localparam logic [7:0] CMD_OD_SKIP = 8'h3c;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;
  // Memory function command bytes
  localparam logic [7:0] CMD_WRITE_PAD = 8'h0f;
  localparam logic [7:0] CMD_REFRESH_PAD = 8'ha3;
  localparam logic [7:0] CMD_READ_PAD = 8'haa;
  localparam logic [7:0] CMD_COPY_PAD = 8'h55;
  localparam logic [7:0] CMD_LOAD_SECRET = 8'h5a;
  // Sizes
  localparam int PAD_BYTES = 8;
  localparam int SECRET_BYTES = 8;
  localparam int PAGE_BYTES = 32;
  localparam int DATA_PAGES = 4;
  localparam int ROM_BYTES = 8;
  localparam int MAC_BYTES = 20;
  localparam int MAC_BITS = 160;
  // Transfer-status layout
  localparam logic [7:0] ES_FIXED_ONES = 8'h5f;
  localparam int PF_BIT = 5;
  localparam int AA_BIT = 7;
  localparam logic [7:0] TA1_KEEP_MASK = 8'hf8;
  localparam logic PF_RESET = 1'b1;
  localparam logic AA_RESET = 1'b0;
  // CRC polynomials, bit-reversed for LSB-first shifting
  localparam logic [7:0] CRC8_POLY = 8'h8c;
  localparam logic [15:0] CRC16_POLY = 16'ha001;
  // Read-scratchpad byte positions
  localparam logic [3:0] TX_TA1 = 4'h0;
  localparam logic [3:0] TX_TA2 = 4'h1;
  localparam logic [3:0] TX_ES = 4'h2;
  localparam logic [3:0] TX_PAD0 = 4'h3;
  localparam logic [3:0] TX_CRC_LO = 4'hb;
  localparam logic [3:0] TX_CRC_HI = 4'hc;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ROM = 4'b0001,
    ST_MATCH = 4'b0010,
    ST_FUNC = 4'b0011,
    ST_ADDR = 4'b0100,
    ST_DATA = 4'b0101,
    ST_MAC = 4'b0110,
    ST_TX = 4'b0111,
    ST_HOLD = 4'b1000
  } swv_state_e;

  function automatic logic [7:0] crc8Bit(logic [7:0] c, logic b);
    logic fb;
    fb = c[0] ^ b;
    return fb ? ((c >> 1) ^ CRC8_POLY) : (c >> 1);
  endfunction

  function automatic logic [15:0] crc16Bit(logic [15:0] c, logic b);
    logic fb;
    fb = c[0] ^ b;
    return fb ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
  endfunction
endpackage
`default_nettype wire

// >>> rtl/swv_crc8.sv
`timescale 1ns/1ns
`default_nettype none
module swv_crc8 #(
  parameter int NBITS = 56
) (
  input wire logic [63:0] dataIn,
  output logic [7:0] crcOut
);
  // Register cleared, bit 0 shifted in first
  always_comb begin
    crcOut = '0;
    for (int i = 0; i < NBITS; i++) begin
      crcOut = swv_pkg::crc8Bit(crcOut, dataIn[i]);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/swv_crc16.sv
`timescale 1ns/1ns
`default_nettype none
module swv_crc16 (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [15:0] crcOut
);
  // Byte update, least significant bit first
  always_comb begin
    crcOut = crcIn;
    for (int i = 0; i < 8; i++) begin
      crcOut = swv_pkg::crc16Bit(crcOut, dataIn[i]);
    end
  end
endmodule
`default_nettype wire

// >>> tb/swv_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module swv_master_model (
  input wire logic sys_clk,
  output logic busReset,
  output logic stdSpeedReset,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxPartial,
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData
);
  int timeouts = 0;
  initial begin
    busReset = 1'b0;
    stdSpeedReset = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
    rxPartial = 1'b0;
    txReady = 1'b0;
  end
  // A one-cycle bus reset opens each transaction
  task automatic initSeq(input logic longReset);
    @(negedge sys_clk);
    busReset = 1'b1;
    stdSpeedReset = longReset;
    @(negedge sys_clk);
    busReset = 1'b0;
    stdSpeedReset = 1'b0;
  endtask
  // One byte, flagged partial when part is set, held whole on rxData for one cycle
  task automatic sendByte(input logic [7:0] b, input logic part);
    @(negedge sys_clk);
    rxValid = 1'b1;
    rxData = b;
    rxPartial = part;
    @(negedge sys_clk);
    rxValid = 1'b0;
    rxData = ~b;
    rxPartial = 1'b0;
  endtask
  // Takes one byte, after an optional stall
  task automatic recvByte(input int stall, output logic [7:0] b);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (txValid !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 50) timeouts++;
    repeat (stall) @(negedge sys_clk);
    b = txData;
    txReady = 1'b1;
    @(negedge sys_clk);
    txReady = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_scratchpad_write_verify.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
  end \
end
module tb_scratchpad_write_verify;
  localparam logic [7:0] FAM = 8'h3e; // Arbitrary value
  localparam logic [47:0] SER = 48'h00a1_b2c3_d4e5; // Arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic busReset, stdSpeedReset, rxValid, rxPartial, txReady;
  logic [7:0] rxData;
  logic txValid, overdriveMode, copyStrobe, secretLoadStrobe;
  logic [7:0] txData, transferStatus, expStat;
  logic [15:0] targetAddr, expAddr;
  logic [63:0] scratchData, padExp;
  logic [159:0] authCode = 160'h0;
  logic [31:0] lfsr = 32'h0000_bf98;
  int n_fail = 0;
  int cmp_count = 0;
  int nCopy = 0;
  int nSecret = 0;
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (copyStrobe === 1'b1) nCopy++;
    if (secretLoadStrobe === 1'b1) nSecret++;
  end
  swv_master_model m (.sys_clk(sys_clk), .busReset(busReset),
    .stdSpeedReset(stdSpeedReset), .rxValid(rxValid), .rxData(rxData),
    .rxPartial(rxPartial), .txValid(txValid), .txReady(txReady),
    .txData(txData));
  swv_top #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) dut (.sys_clk(sys_clk),
    .rst(rst), .busReset(busReset), .stdSpeedReset(stdSpeedReset),
    .rxValid(rxValid), .rxData(rxData), .rxPartial(rxPartial),
    .txValid(txValid), .txReady(txReady), .txData(txData),
    .authCode(authCode), .overdriveMode(overdriveMode),
    .copyStrobe(copyStrobe), .secretLoadStrobe(secretLoadStrobe),
    .targetAddr(targetAddr), .scratchData(scratchData),
    .transferStatus(transferStatus));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] crc8Ref(logic [63:0] v, int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction
  function automatic logic [15:0] crcB(logic [15:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction
  task automatic results();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic recv(input int stall, output logic [7:0] b);
    m.recvByte(stall, b);
    if (m.timeouts != 0) begin
      n_fail++;
      results();
    end
  endtask
  task automatic open(input logic [7:0] cmd);
    m.initSeq(1'b0);
    m.sendByte(swv_pkg::CMD_SKIP_ROM, 1'b0);
    m.sendByte(cmd, 1'b0);
  endtask
  // Master sends address then eight bytes, stopping after a partial byte at shortAt
  task automatic doWrite(input logic [7:0] cmd, input int shortAt);
    logic [15:0] c;
    logic [7:0] lo, hi, b, r;
    lo = rnd();
    hi = rnd();
    open(cmd);
    m.sendByte(lo, 1'b0);
    m.sendByte(hi, 1'b0);
    c = crcB(crcB(crcB(16'h0000, cmd), lo), hi);
    expStat = 8'h7f;
    for (int i = 0; i < 8; i++) begin
      b = rnd();
      m.sendByte(b, i == shortAt);
      if (i == shortAt) return;
      padExp[8*i+:8] = b;
      c = crcB(c, b);
    end
    expAddr = {hi, lo & 8'hf8};
    expStat = 8'h5f;
    recv(0, r);
    `CHK(r, ~c[7:0])
    recv(3, r);
    `CHK(r, ~c[15:8])
    `CHK(transferStatus, expStat)
  endtask
  // Read back after each complete write
  task automatic doRead();
    logic [15:0] c;
    logic [7:0] r, e;
    open(swv_pkg::CMD_READ_PAD);
    c = crcB(16'h0000, swv_pkg::CMD_READ_PAD);
    for (int i = 0; i < 13; i++) begin
      e = (i == 0) ? expAddr[7:0] : (i == 1) ? expAddr[15:8] :
          (i == 2) ? expStat : (i == 11) ? ~c[7:0] :
          (i == 12) ? ~c[15:8] : padExp[8*(i-3)+:8];
      recv(int'(rnd() & 8'h03), r);
      `CHK(r, e)
      if (i < 11) c = crcB(c, e);
    end
    `CHK(targetAddr, expAddr)
    `CHK(scratchData, padExp)
  endtask
  task automatic doCopy(input logic good, input int expN);
    int n0;
    n0 = nCopy;
    open(swv_pkg::CMD_COPY_PAD);
    for (int i = 0; i < 20; i++)
      m.sendByte(authCode[8*i+:8] ^ {7'h00, !good && i == 19}, 1'b0);
    repeat (3) @(negedge sys_clk);
    if (expN == 1) expStat = 8'hdf;
    `CHK(nCopy - n0, expN)
    `CHK(transferStatus, expStat)
  endtask
  initial begin
    logic [63:0] rom;
    logic [7:0] r;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 20; i++) authCode[8*i+:8] = rnd();
    `CHK(transferStatus, 8'h7f)
    `CHK(txValid, 1'b0)
    m.initSeq(1'b0);
    m.sendByte(swv_pkg::CMD_READ_ROM, 1'b0);
    for (int i = 0; i < 8; i++) recv(i % 3, rom[8*i+:8]);
    `CHK(rom[55:0], {SER, FAM})
    `CHK(rom[63:56], crc8Ref(rom, 56))
    `CHK(crc8Ref(rom, 64), 8'h00)
    $display("Test registration done");
    m.initSeq(1'b0);
    m.sendByte(swv_pkg::CMD_READ_PAD, 1'b0);
    repeat (6) @(negedge sys_clk);
    `CHK(txValid, 1'b0)
    $display("Test command gating done");
    for (int k = 0; k < 3; k++) begin
      doWrite(swv_pkg::CMD_WRITE_PAD, 9);
      doRead();
    end
    $display("Test write and read done");
    doCopy(1'b0, 0);
    doCopy(1'b1, 1);
    doRead();
    doWrite(swv_pkg::CMD_WRITE_PAD, 9);
    doRead();
    $display("Test copy done");
    doWrite(swv_pkg::CMD_WRITE_PAD, 4);
    repeat (2) @(negedge sys_clk);
    `CHK(transferStatus, 8'h7f)
    doCopy(1'b1, 0);
    doWrite(swv_pkg::CMD_REFRESH_PAD, 9);
    doRead();
    $display("Test partial and refresh done");
    nSecret = 0;
    open(swv_pkg::CMD_LOAD_SECRET);
    repeat (3) @(negedge sys_clk);
    `CHK(nSecret, 1)
    `CHK(transferStatus, 8'hdf)
    $display("Test secret load done");
    rom = {crc8Ref({8'h00, SER, FAM}, 56), SER, FAM};
    for (int k = 0; k < 2; k++) begin
      m.initSeq(1'b0);
      if (k == 0) begin
        m.sendByte(swv_pkg::CMD_MATCH_ROM, 1'b0);
        for (int i = 0; i < 8; i++) m.sendByte(rom[8*i+:8], 1'b0);
      end else begin
        m.sendByte(swv_pkg::CMD_RESUME, 1'b0);
      end
      m.sendByte(swv_pkg::CMD_READ_PAD, 1'b0);
      recv(0, r);
      `CHK(r, expAddr[7:0])
    end
    $display("Test match and resume done");
    m.initSeq(1'b0);
    m.sendByte(swv_pkg::CMD_OD_SKIP, 1'b0);
    repeat (2) @(negedge sys_clk);
    `CHK(overdriveMode, 1'b1)
    m.initSeq(1'b1);
    @(negedge sys_clk);
    `CHK(overdriveMode, 1'b0)
    $display("Test overdrive done");
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    `CHK(transferStatus, 8'h7f)
    $display("Test second reset done");
    results();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
